// File: testbench/mbp_chk.sv
// Purpose: Port-level assertions for the serial port setup
// Assumes: Port setup mirrored from register writes
// Notes:   A frame may start up to one ms tick early
`timescale 1ns/1ps
module mbp_chk #(
  parameter MS_CYCLES = 10
) (
  input wire        clk,
  input wire        reset_n,
  input wire [3:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  input wire        rxd,
  input wire        cts,
  input wire        txd,
  input wire        rts
);
  logic        en_q;
  logic [15:0] bd_q, ld_q, tl_q;
  int          up_q, hi_q, lo_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      bd_q <= 16'h01B2;
      {tl_q, ld_q} <= 32'h0000_0000;
      up_q <= 0;
      hi_q <= 0;
      lo_q <= 0;
    end else begin
      if (wr && addr == 4'h0) en_q <= wdata[0];
      if (wr && addr == 4'h1) bd_q <= wdata[15:0];
      if (wr && addr == 4'h2) {tl_q, ld_q} <= wdata;
      up_q <= rts ? up_q + 1 : 0;
      hi_q <= txd ? hi_q + 1 : 0;
      lo_q <= txd ? 0 : lo_q + 1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_rdz;
    !$past(rd) |-> rdata == 32'h0000_0000;
  endproperty
  a_rdz: assert property (p_rdz) else $error("stray read data");
  property p_idle;
    !rts |-> txd;
  endproperty
  a_idle: assert property (p_idle) else $error("sent without rts");
  property p_dis;
    !en_q [*3] |-> !rts;
  endproperty
  a_dis: assert property (p_dis) else $error("rts on while off");
  property p_start;
    $rose(rts) |-> $past(wr, 2) && $past(addr, 2) == 4'h4;
  endproperty
  a_start: assert property (p_start) else $error("rts unasked");
  property p_lead;
    $fell(txd) |-> up_q + MS_CYCLES >= ld_q * MS_CYCLES;
  endproperty
  a_lead: assert property (p_lead) else $error("lead short");
  property p_tlo;
    $fell(rts) && en_q |-> hi_q + MS_CYCLES >= tl_q * MS_CYCLES + bd_q;
  endproperty
  a_tlo: assert property (p_tlo) else $error("tail short");
  property p_thi;
    $fell(rts) && en_q |-> hi_q <= (tl_q + 1) * MS_CYCLES + 11 * bd_q + 8;
  endproperty
  a_thi: assert property (p_thi) else $error("tail long");
  property p_bit;
    $rose(txd) |-> lo_q % bd_q == 0;
  endproperty
  a_bit: assert property (p_bit) else $error("bit time off");
endmodule

// File: testbench/mbp_far.sv
// Purpose: Far-side serial device: decodes port output, sends characters
// Assumes: fmt is {two stop, eight data, parity[1:0]}
// Notes:   Idle line rests high as on a biased shared line
`timescale 1ns/1ps
module mbp_far (
  input  wire        clk,
  input  wire        txd,
  input  wire [15:0] bd,
  input  wire [3:0]  fmt,
  output logic       rxd,
  output logic       got,
  output logic [8:0] dat
);
  int   i;
  logic p;
  initial begin
    rxd = 1'b1;
    got = 1'b0;
  end
  // Top bit flags bad parity or a missing stop bit
  always begin
    @(negedge txd);
    repeat (bd / 2) @(posedge clk);
    dat = 9'h000;
    p = fmt[1:0] == 2'h1;
    for (i = 0; i < (fmt[2] ? 8 : 7); i++) begin
      repeat (bd) @(posedge clk);
      dat[i] = txd;
      p ^= txd;
    end
    for (i = 0; i < (fmt[1:0] != 2'h0) + fmt[3] + 1; i++) begin
      repeat (bd) @(posedge clk);
      dat[8] = dat[8] | (txd !== (i == 0 && fmt[1:0] != 2'h0 ? p : 1'b1));
    end
    @(negedge clk);
    got = 1'b1;
    @(negedge clk);
    got = 1'b0;
  end
  task automatic send(input logic [7:0] b, input logic flip);
    int   k;
    logic q;
    q = (fmt[1:0] == 2'h1) ^ flip;
    rxd <= 1'b0;
    repeat (bd) @(posedge clk);
    for (k = 0; k < (fmt[2] ? 8 : 7); k++) begin
      rxd <= b[k];
      q ^= b[k];
      repeat (bd) @(posedge clk);
    end
    if (fmt[1:0] != 2'h0) begin
      rxd <= q;
      repeat (bd) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (bd * (fmt[3] + 1)) @(posedge clk);
  endtask
endmodule

// File: testbench/tb_modbus_serial_port_setup.sv
// Purpose: Self-checking bench for the serial port setup
// Assumes: ms tick shortened to 10 clocks
// Notes:   Reads and received characters are checked from queues
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_modbus_serial_port_setup;
  localparam MS = 10;
  logic        clk, reset_n, wr, rd, cts, txd, rts, rxd, got, rd_d;
  logic [3:0]  addr, fmt;
  logic [31:0] wdata, rdata;
  logic [15:0] bd, bs, ofs, r;
  logic [8:0]  dat;
  logic [63:0] e;
  logic [63:0] rq[$];
  logic [8:0]  bq[$];
  int          n_errors = 0, checks_done = 0, cyc = 0, f, k, j;
  int          fct[6] = '{1, 3, 4, 6, 16, 23};
  initial begin
    {clk, reset_n, wr, rd, cts, rd_d} = 6'h00;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    bd = 16'h01B2;
    fmt = 4'h4;
  end
  always #10 clk = ~clk;
  mbport_top #(.MS_CYCLES(MS)) i_mbport_top (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .cts(cts), .txd(txd),
    .rts(rts));
  mbp_far i_mbp_far (.clk(clk), .txd(txd), .bd(bd), .fmt(fmt), .rxd(rxd), .got(got),
    .dat(dat));
  always @(posedge clk) begin
    cyc++;
    if (rd_d) begin
      e = rq.pop_front();
      `CHK(rdata & e[31:0], e[63:32])
    end
    rd_d = rd;
    if (got) begin
      e = bq.pop_front();
      `CHK(dat, e[8:0])
    end
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
    rq.push_back({x & m, m});
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic xwait();
    k = 0;
    repeat (2) @(posedge clk);
    while (rts !== 1'b0 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic results();
    $display("TB: %0d checks, %0d errors", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    k = $urandom(32'hda4e_6204);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rreg(4'h0, 32'h0001_0020, '1);
    rreg(4'h1, 32'h0000_01B2, '1);
    rreg(4'h2, 32'h0000_0000, '1);
    rreg(4'h3, 32'h0000_0000, '1);
    wreg(4'hC, '1);
    rreg(4'hC, 32'h0000_0000, '1);
    wreg(4'h4, 32'h0000_0055);
    repeat (20) @(posedge clk);
    rreg(4'h6, 32'h0000_0040, 32'h0000_07F0);
    wreg(4'h0, 32'h0000_0021);
    rreg(4'h0, 32'h0001_0021, '1);
    $display("TB: reset and disable test done");
    for (f = 0; f < 32; f++) begin
      if (f[1:0] == 2'h3)
        continue;
      j = $urandom % 2;
      fmt <= f[3:0];
      bd <= 16'h0004 + 16'($urandom % 12);
      wreg(4'h0, {16'h0001, 8'h00, 1'b0, f[3:0], f[4], j[0], 1'b1});
      wreg(4'h1, {16'h0000, bd});
      wreg(4'h2, $urandom & 32'h0003_0003);
      rreg(4'h6, {18'h0, f[4], j[0], 12'h000}, 32'h0000_3000);
      r = 16'($urandom % 256);
      wreg(4'h4, {16'h0000, r});
      bq.push_back({1'b0, fmt[2] ? r[7:0] : {1'b0, r[6:0]}});
      xwait();
    end
    $display("TB: character format test done");
    fmt <= 4'h4;
    wreg(4'h0, 32'h0001_00A1);
    wreg(4'h4, 32'h0000_00C3);
    bq.push_back(9'h0C3);
    repeat (400) @(posedge clk);
    rreg(4'h6, 32'h0000_0120, 32'h0000_07E0);
    cts <= 1'b1;
    xwait();
    $display("TB: clear to send test done");
    cts <= 1'b0;
    fmt <= 4'h6;
    wreg(4'h0, 32'h0005_0031);
    i_mbp_far.send(8'h05, 1'b0);
    repeat (8) @(posedge clk);
    rreg(4'h6, 32'h0000_0801, 32'h0000_0807);
    rreg(4'h5, 32'h0000_0005, 32'h0000_00FF);
    i_mbp_far.send(8'h3C, 1'b1);
    repeat (8) @(posedge clk);
    rreg(4'h6, 32'h0000_0003, 32'h0000_0807);
    rreg(4'h5, 32'h0000_003C, 32'h0000_00FF);
    fmt <= 4'h0;
    wreg(4'h0, 32'h0005_0001);
    i_mbp_far.send(8'h45, 1'b0);
    repeat (8) @(posedge clk);
    rreg(4'h6, 32'h0000_0001, 32'h0000_0807);
    rreg(4'h5, 32'h0000_0045, 32'h0000_00FF);
    $display("TB: receive test done");
    wreg(4'h3, 32'hFFFF_1B58);
    rreg(4'h3, 32'h270E_1B58, '1);
    bs = 16'h0040 + 16'($urandom % 60000);
    ofs = 16'($urandom % 9999);
    wreg(4'h3, {ofs, bs});
    for (j = 0; j < 12; j++) begin
      wreg(4'h0, {16'h0001, 7'h00, j >= 6, 8'h21});
      r = bs + 16'($urandom % 64) - 16'h0010;
      wreg(4'h7, {8'h00, 8'(fct[j % 6]), r});
      f = j >= 6 && r >= bs && fct[j % 6] inside {3, 6, 16};
      rreg(4'h7, {15'h0, f[0], ofs + r - bs}, f ? 32'h0001_FFFF : 32'h0001_0000);
    end
    $display("TB: float window test done");
    repeat (20) @(posedge clk);
    `CHK(bq.size(), 0)
    results();
  end
endmodule
bind mbport_top mbp_chk #(.MS_CYCLES(MS_CYCLES)) i_mbp_chk (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .cts(cts),
  .txd(txd), .rts(rts));

// File: verilog/mbport_defs.vh
// Purpose: Offsets, field positions, reset values and timing counts of the serial port setup
// Assumes: 50 MHz system clock, 32-bit register port
// Notes:   Included by the port top module only
`ifndef MBPORT_DEFS_VH
`define MBPORT_DEFS_VH

`define MBP_CLK_HZ        50000000
`define MBP_MS_PER_S      1000
`define MBP_MS_CYCLES     (`MBP_CLK_HZ / `MBP_MS_PER_S)

`define MBP_REG_CTRL      4'h0
`define MBP_REG_BAUD      4'h1
`define MBP_REG_RTS       4'h2
`define MBP_REG_FLOAT     4'h3
`define MBP_REG_TXDATA    4'h4
`define MBP_REG_RXDATA    4'h5
`define MBP_REG_STATUS    4'h6
`define MBP_REG_MAP       4'h7

`define MBP_CTRL_EN       0
`define MBP_CTRL_MASTER   1
`define MBP_CTRL_ASCII    2
`define MBP_CTRL_PAR_LO   3
`define MBP_CTRL_PAR_HI   4
`define MBP_CTRL_DB8      5
`define MBP_CTRL_SB2      6
`define MBP_CTRL_CTS      7
`define MBP_CTRL_FLOAT    8
`define MBP_CTRL_NODE_LO  16
`define MBP_CTRL_NODE_HI  23

`define MBP_CTRL_RST      32'h0001_0020
`define MBP_BAUD_RST      16'h01B2
`define MBP_PAR_NONE      2'h0
`define MBP_PAR_ODD       2'h1
`define MBP_PAR_EVEN      2'h2
`define MBP_FLOAT_OFS_MAX 16'h270E
`define MBP_NODE_MAX      8'hF7

`endif

// File: verilog/mbport_top.v
// Purpose: Serial port front end for Modbus traffic: framing, RTS/CTS timing, float window map
// Assumes: Single 50 MHz clock, register port with read data one cycle after read strobe
// Notes:   Message level protocol (frame checks, role logic) runs in software above
`timescale 1ns/1ps
`include "mbport_defs.vh"

// Function
// - Disabled port neither transmits nor receives
// - Master originates requests; slave only answers
// - Float mapping only for functions 3,6,16
// - Registers at or above base are float
// - Base register maps to database offset
// - Framing selectable between RTU and ASCII
// - RTU carries CRC-16, ASCII carries LRC
// - Parity none, odd or even generated/checked
// - Seven or eight data bits
// - One or two stop bits
// - One stop typical, two for slow
// - One baud setting for transmit and receive
// - Lead delay after RTS before sending
// - Tail delay after last byte, then RTS low
// - CTS gating withholds sending until CTS high
// - CTS ignored when gating disabled
// - Slave answers only its node address
module mbport_top #(
  parameter MS_CYCLES = `MBP_MS_CYCLES
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire        rxd,
  input  wire        cts,
  output reg         txd,
  output reg         rts
);

  localparam ST_IDLE = 5'b00001;
  localparam ST_LEAD = 5'b00010;
  localparam ST_CTS  = 5'b00100;
  localparam ST_SEND = 5'b01000;
  localparam ST_TAIL = 5'b10000;

  reg  [31:0] ctrl_q;
  reg  [15:0] baud_q;
  reg  [15:0] lead_q, tail_q;
  reg  [15:0] fbase_q, fofs_q;
  reg  [15:0] map_q;
  reg  [7:0]  txbuf_q;
  reg         txfull_q;
  reg  [7:0]  rxbuf_q;
  reg         rxvalid_q, rxperr_q, rxferr_q, rxovr_q;
  reg  [15:0] map_res_q;
  reg         map_hit_q;

  wire        en      = ctrl_q[`MBP_CTRL_EN];
  wire        master  = ctrl_q[`MBP_CTRL_MASTER];
  wire        ascii   = ctrl_q[`MBP_CTRL_ASCII];
  wire [1:0]  par     = ctrl_q[`MBP_CTRL_PAR_HI:`MBP_CTRL_PAR_LO];
  wire        db8     = ctrl_q[`MBP_CTRL_DB8];
  wire        sb2     = ctrl_q[`MBP_CTRL_SB2];
  wire        use_cts = ctrl_q[`MBP_CTRL_CTS];
  wire        fl_en   = ctrl_q[`MBP_CTRL_FLOAT];
  wire [7:0]  node    = ctrl_q[`MBP_CTRL_NODE_HI:`MBP_CTRL_NODE_LO];

  // Millisecond tick for RTS delays
  reg [31:0] ms_cnt_q;
  wire       ms_tick = (ms_cnt_q == MS_CYCLES - 1);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_q <= 32'h0000_0000;
    end else if (ms_tick) begin
      ms_cnt_q <= 32'h0000_0000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
    end
  end

  // Input synchronisers: stage 1 feeds only stage 2
  reg [2:0] rx_s_q, cts_s_q;
  reg       rx_f_q, cts_f_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s_q  <= 3'h7;
      cts_s_q <= 3'h0;
      rx_f_q  <= 1'b1;
      cts_f_q <= 1'b0;
    end else begin
      rx_s_q  <= {rx_s_q[1:0], rxd};
      cts_s_q <= {cts_s_q[1:0], cts};
      if (rx_s_q[1] == rx_s_q[2]) begin
        rx_f_q <= rx_s_q[2];
      end
      if (cts_s_q[1] == cts_s_q[2]) begin
        cts_f_q <= cts_s_q[2];
      end
    end
  end

  // Parity over the active data bits
  function par_bit;
    input [7:0] d;
    input       d8;
    input [1:0] p;
    reg         x;
    begin
      x = ^d[6:0] ^ (d8 & d[7]);
      par_bit = (p == `MBP_PAR_ODD) ? ~x : x;
    end
  endfunction

  // Register writes and float window mapping
  wire [15:0] map_dist = map_q - fbase_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q    <= `MBP_CTRL_RST;
      baud_q    <= `MBP_BAUD_RST;
      lead_q    <= 16'h0000;
      tail_q    <= 16'h0000;
      fbase_q   <= 16'h0000;
      fofs_q    <= 16'h0000;
      map_q     <= 16'h0000;
      map_res_q <= 16'h0000;
      map_hit_q <= 1'b0;
    end else begin
      if (wr) begin
        case (addr)
          `MBP_REG_CTRL: begin
            ctrl_q <= wdata;
            if (wdata[`MBP_CTRL_NODE_HI:`MBP_CTRL_NODE_LO] == 8'h00 ||
                wdata[`MBP_CTRL_NODE_HI:`MBP_CTRL_NODE_LO] > `MBP_NODE_MAX) begin
              ctrl_q[`MBP_CTRL_NODE_HI:`MBP_CTRL_NODE_LO] <= node;
            end
          end
          `MBP_REG_BAUD: baud_q <= (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
          `MBP_REG_RTS: begin
            lead_q <= wdata[15:0];
            tail_q <= wdata[31:16];
          end
          `MBP_REG_FLOAT: begin
            fbase_q <= wdata[15:0];
            fofs_q  <= (wdata[31:16] > `MBP_FLOAT_OFS_MAX) ? `MBP_FLOAT_OFS_MAX
                                                             : wdata[31:16];
          end
          `MBP_REG_MAP: map_q <= wdata[15:0];
          default: ;
        endcase
      end
      // Map request: low 16 bits register, bits 23:16 function code
      if (wr && addr == `MBP_REG_MAP) begin
        map_hit_q <= fl_en && wdata[15:0] >= fbase_q &&
                     (wdata[23:16] == 8'h03 || wdata[23:16] == 8'h06 ||
                      wdata[23:16] == 8'h10);
      end
      map_res_q <= fofs_q + map_dist;
    end
  end

  // Transmitter with RTS lead/tail and CTS gating
  reg [4:0]  st_q;
  reg [15:0] dly_q;
  reg [15:0] tbaud_q;
  reg [3:0]  tbit_q;
  reg [11:0] tsh_q;
  wire [3:0] nbits = 4'd1 + (db8 ? 4'd8 : 4'd7) + ((par != `MBP_PAR_NONE) ? 4'd1 : 4'd0) +
                     (sb2 ? 4'd2 : 4'd1);
  wire       tx_load = wr && addr == `MBP_REG_TXDATA && en;
  wire       tx_done;
  wire       baud_tick_t = (tbaud_q == baud_q - 16'h0001);
  assign tx_done = (st_q == ST_SEND) && baud_tick_t && (tbit_q == nbits - 4'd1);
  wire [7:0] tx_dat = db8 ? txbuf_q : {1'b0, txbuf_q[6:0]};
  wire [11:0] frame = db8 ?
    ((par != `MBP_PAR_NONE) ? {2'b11, par_bit(tx_dat, 1'b1, par), tx_dat, 1'b0}
                             : {3'b111, tx_dat, 1'b0}) :
    ((par != `MBP_PAR_NONE) ? {3'b111, par_bit(tx_dat, 1'b0, par), tx_dat[6:0], 1'b0}
                             : {4'b1111, tx_dat[6:0], 1'b0});

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q     <= ST_IDLE;
      dly_q    <= 16'h0000;
      tbaud_q  <= 16'h0000;
      tbit_q   <= 4'h0;
      tsh_q    <= 12'hFFF;
      txd      <= 1'b1;
      rts      <= 1'b0;
      txbuf_q  <= 8'h00;
      txfull_q <= 1'b0;
    end else begin
      if (tx_load && !txfull_q) begin
        txbuf_q  <= wdata[7:0];
        txfull_q <= 1'b1;
      end
      if (!en) begin
        st_q     <= ST_IDLE;
        rts      <= 1'b0;
        txd      <= 1'b1;
        txfull_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: if (txfull_q) begin
            rts   <= 1'b1;
            dly_q <= lead_q;
            st_q  <= ST_LEAD;
          end
          ST_LEAD: if (dly_q == 16'h0000) begin
            st_q <= ST_CTS;
          end else if (ms_tick) begin
            dly_q <= dly_q - 16'h0001;
          end
          ST_CTS: if (!use_cts || cts_f_q) begin
            tsh_q    <= frame;
            txd      <= 1'b0;
            tbit_q   <= 4'h0;
            tbaud_q  <= 16'h0000;
            txfull_q <= 1'b0;
            st_q     <= ST_SEND;
          end
          ST_SEND: begin
            tbaud_q <= baud_tick_t ? 16'h0000 : tbaud_q + 16'h0001;
            if (tx_done) begin
              txd <= 1'b1;
              if (txfull_q) begin
                st_q <= ST_CTS; // Back to back bytes keep RTS up
              end else begin
                dly_q <= tail_q;
                st_q  <= ST_TAIL;
              end
            end else if (baud_tick_t) begin
              tbit_q <= tbit_q + 4'd1;
              tsh_q  <= {1'b1, tsh_q[11:1]};
              txd    <= tsh_q[1];
            end
          end
          ST_TAIL: if (txfull_q) begin
            st_q <= ST_CTS;
          end else if (dly_q == 16'h0000) begin
            rts  <= 1'b0;
            st_q <= ST_IDLE;
          end else if (ms_tick) begin
            dly_q <= dly_q - 16'h0001;
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Receiver: samples mid bit at the shared baud setting
  reg        rbusy_q;
  reg [15:0] rbaud_q;
  reg [3:0]  rbit_q;
  reg [10:0] rsh_q;
  wire       rx_mid  = (rbaud_q == {1'b0, baud_q[15:1]});
  wire [3:0] rx_last = nbits - (sb2 ? 4'd2 : 4'd1);
  wire       rx_read = rd && addr == `MBP_REG_RXDATA;
  wire [10:0] rx_frm = {rx_f_q, rsh_q[10:1]};
  wire [10:0] rx_al  = rx_frm >> (4'hA - rx_last); // Short frames sit high in the shifter
  wire [7:0] rx_dat  = db8 ? rx_al[8:1] : {1'b0, rx_al[7:1]};
  wire       rx_pb   = rx_frm[9];
  wire       rx_stop = rx_frm[10];
  wire       rx_done = rbusy_q && rx_mid && rbit_q == rx_last;
  // Slave address filter applies to software via status; hardware keeps every byte, but a slave only starts receiving while st_q is ST_IDLE
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rbusy_q   <= 1'b0;
      rbaud_q   <= 16'h0000;
      rbit_q    <= 4'h0;
      rsh_q     <= 11'h000;
      rxbuf_q   <= 8'h00;
      rxvalid_q <= 1'b0;
      rxperr_q  <= 1'b0;
      rxferr_q  <= 1'b0;
      rxovr_q   <= 1'b0;
    end else if (!en) begin
      rbusy_q   <= 1'b0;
      rxvalid_q <= 1'b0;
    end else begin
      if (rx_read) begin
        rxvalid_q <= 1'b0;
        rxperr_q  <= 1'b0;
        rxferr_q  <= 1'b0;
        rxovr_q   <= 1'b0;
      end
      if (!rbusy_q) begin
        if (!rx_f_q && (st_q == ST_IDLE || master)) begin
          rbusy_q <= 1'b1;
          rbaud_q <= 16'h0000;
          rbit_q  <= 4'h0;
        end
      end else begin
        rbaud_q <= (rbaud_q == baud_q - 16'h0001) ? 16'h0000 : rbaud_q + 16'h0001;
        if (rx_mid) begin
          rsh_q  <= rx_frm;
          rbit_q <= rbit_q + 4'd1;
          if (rbit_q == 4'h0 && rx_f_q) begin
            rbusy_q <= 1'b0; // False start
          end
        end
        if (rx_done) begin // Set wins over a same-cycle read
          rbusy_q   <= 1'b0;
          rxbuf_q   <= rx_dat;
          rxvalid_q <= 1'b1;
          rxovr_q   <= rxvalid_q && !rx_read;
          rxperr_q  <= (par != `MBP_PAR_NONE) &&
                       (rx_pb != par_bit(rx_dat, db8, par));
          rxferr_q  <= !rx_stop;
        end
      end
    end
  end

  // Read port; node match bit lets slave software drop foreign frames
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `MBP_REG_CTRL:   rdata <= ctrl_q;
        `MBP_REG_BAUD:   rdata <= {16'h0000, baud_q};
        `MBP_REG_RTS:    rdata <= {tail_q, lead_q};
        `MBP_REG_FLOAT:  rdata <= {fofs_q, fbase_q};
        `MBP_REG_RXDATA: rdata <= {24'h00_0000, rxbuf_q};
        `MBP_REG_STATUS: rdata <= {18'h0_0000, ascii, master && en,
                                   (!master && rxbuf_q == node),
                                   st_q, rts, txfull_q, rxovr_q, rxferr_q, rxperr_q,
                                   rxvalid_q};
        `MBP_REG_MAP:    rdata <= {15'h0000, map_hit_q, map_res_q};
        default:         rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule
